// ===== src/possel_regs.svh
// Constants of the position selector: register offsets, fields, timing counts
//
// Overview of operation
// [R1] Top setting limits valid positions 1..top.
// [R2] Step edge advances pre-selection, wraps to 1.
// [R3] Step edges no closer than 50 ms; the code accepts step edges at any spacing.
// [R4] Any control activity restarts the time-out.
// [R5] Step time-out mode applies after inactivity.
// [R6] Step acknowledge mode applies on confirm edge.
// [R7] Missing step confirm discards, alarms 3 s.
// [R8] Code 1..7 selects position, 000 rests.
// [R9] Rest code changes nothing.
// [R10] Code above top: no change, alarm 3 s.
// [R11] Code time-out mode applies after inactivity.
// [R12] Code acknowledge applies on in-time confirm edge.
// [R13] Missing code confirm rejects, alarms 3 s.
// [R14] Step and code paths lock each other out.
// [R15] Each path has its own confirm input.
// [R16] Active position is written to storage.
// [R17] Restore policy loads stored position, checks range.
// [R18] Synchronize policy adopts code at power-up.
// [R19] Bad code at sync power-up: position 0, alarm.
// [R20] Log position changes and confirm alarms.
// [R21] Outputs one-hot and binary; 0 drives none.
// [R22] All times count a 1 ms tick.
`ifndef POSSEL_REGS_SVH
`define POSSEL_REGS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses on the Wishbone slave)
// ---------------------------------------------------------------
`define PS_REG_CTRL     4'h0
`define PS_REG_TIMEOUT  4'h4
`define PS_REG_STATUS   4'h8
`define PS_REG_EVENT    4'hc

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define PS_CTRL_TOP_LSB    0
`define PS_CTRL_STEPMODE   3
`define PS_CTRL_CODEMODE   4
`define PS_CTRL_POLICY     5
`define PS_CTRL_EVLOG      6
`define PS_CTRL_RESET      32'h0000_0007

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define PS_CLK_HZ          40000000
`define PS_TICK_MS         1
`define PS_TICK_CYCLES     (`PS_CLK_HZ / 1000 * `PS_TICK_MS)
`define PS_ALARM_S         3
`define PS_ALARM_MS        (`PS_ALARM_S * 1000)
`define PS_TIMEOUT_RESET   16'h1388

`endif

// ===== src/possel_pkg.sv
// Types shared by the position selector
package possel_pkg;
    // ---------------------------------------------------------------
    // Sequence state: which path owns a pending pre-selection
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        POSSEL_IDLE,
        POSSEL_STEP,
        POSSEL_CODE
    } possel_seq_e;
    typedef logic [2:0] possel_pos_t;   // Position 0..7
endpackage

// ===== src/possel_alarm.sv
// Retriggerable millisecond alarm stretcher used for the step confirm, code confirm and code range alarm outputs
`include "possel_regs.svh"
module possel_alarm #(
    parameter int unsigned HOLD_MS = `PS_ALARM_MS  // Alarm length in ticks
) (
    input  wire logic core_clk_in,   // System clock
    input  wire logic rst_n_in,      // Synchronous reset, active low
    input  wire logic tick_in,       // 1 ms tick
    input  wire logic fire_in,       // Start or restart the alarm
    output logic      alarm_out      // Alarm level, registered
);
    logic [15:0] cnt_q;              // Remaining ticks

    // ---------------------------------------------------------------
    // Countdown; a fresh fire restarts the full length
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            cnt_q     <= 16'h0000;
            alarm_out <= 1'b0;
        end else if (fire_in) begin
            cnt_q     <= 16'(HOLD_MS);   // [R22]
            alarm_out <= 1'b1;
        end else if (tick_in && cnt_q != 16'h0000) begin
            cnt_q     <= cnt_q - 16'h0001;
            alarm_out <= (cnt_q != 16'h0001);
        end
    end

    // Alarm must stand the cycle after a fire
    a_alarm_follow: assert property (@(posedge core_clk_in) disable iff (!rst_n_in) // [R22]
        fire_in |=> alarm_out) else $error("alarm did not start");
endmodule

// ===== src/possel_top.sv
// Position selector switch: step and code control, time-out, alarms, storage
`include "possel_regs.svh"
module possel_top
    import possel_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `PS_TICK_CYCLES,  // Clocks per 1 ms
    parameter int unsigned ALARM_MS    = `PS_ALARM_MS      // Alarm length
) (
    input  wire logic        core_clk_in,        // 40 MHz system clock
    input  wire logic        rst_n_in,           // Synchronous reset, low
    // Wishbone classic slave
    input  wire logic        wb_cyc_in,          // Cycle
    input  wire logic        wb_stb_in,          // Strobe
    input  wire logic        wb_we_in,           // Write enable
    input  wire logic [3:0]  wb_adr_in,          // Byte address
    input  wire logic [3:0]  wb_sel_in,          // Byte lanes
    input  wire logic [31:0] wb_dat_in,          // Write data
    output logic [31:0]      wb_dat_out,         // Read data
    output logic             wb_ack_out,         // Acknowledge
    // Control inputs from the field side
    input  wire logic        step_pulse_in,      // Step control
    input  wire logic        step_confirm_in,    // Step acknowledge
    input  wire logic        code_bit_0,         // Code bit 0
    input  wire logic        code_bit_1,         // Code bit 1
    input  wire logic        code_bit_2,         // Code bit 2
    input  wire logic        code_confirm_in,    // Code acknowledge
    // Non-volatile storage port
    input  wire logic [2:0]  nv_pos_in,          // Stored position
    output logic [2:0]       nv_pos_out,         // Position to store
    output logic             nv_write_out,       // Store strobe
    // Results
    output logic [7:1]       pos_onehot_out,     // One-hot position
    output logic [2:0]       pos_bin_out,        // Binary position
    output logic             step_confirm_alarm, // Step confirm timed out
    output logic             code_confirm_alarm, // Code confirm timed out
    output logic             code_range_alarm,   // Code above top
    output logic             powerup_alarm,      // Power-up fault
    output logic             event_valid_out,    // Event log strobe
    output logic [3:0]       event_code_out      // Event kind and value
);
    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    logic [6:0]  ctrl_q;          // Top, modes, policy, logging
    logic [15:0] timeout_ms_q;    // Time-out in ms
    possel_pos_t top_w;           // Highest usable position
    logic        step_ack_mode;   // 1: step acknowledge
    logic        code_ack_mode;   // 1: code acknowledge
    logic        policy_sync;     // 1: synchronize at power-up
    logic        evlog_en;        // Event logging enabled

    assign top_w         = ctrl_q[`PS_CTRL_TOP_LSB +: 3];
    assign step_ack_mode = ctrl_q[`PS_CTRL_STEPMODE];
    assign code_ack_mode = ctrl_q[`PS_CTRL_CODEMODE];
    assign policy_sync   = ctrl_q[`PS_CTRL_POLICY];
    assign evlog_en      = ctrl_q[`PS_CTRL_EVLOG];

    // Position inside 1..top
    function automatic logic in_range(input possel_pos_t p, input possel_pos_t top);
        in_range = (p != 3'h0) && (p <= top);   // [R1]
    endfunction

    // ---------------------------------------------------------------
    // Input synchronisers: two flops, then edge detection on the third
    // ---------------------------------------------------------------
    logic [4:0] sync1_q;          // First stage only feeds second
    logic [4:0] sync2_q;          // Stable copies
    logic [4:0] prev_q;           // For edges and changes
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
            prev_q  <= 5'h00;
        end else begin
            sync1_q <= {code_confirm_in, step_confirm_in,
                        code_bit_2, code_bit_1, code_bit_0};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end
    // Step pulse has its own pair to keep the vector simple
    logic step_s1_q, step_s2_q, step_prev_q;
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            step_s1_q   <= 1'b0;
            step_s2_q   <= 1'b0;
            step_prev_q <= 1'b0;
        end else begin
            step_s1_q   <= step_pulse_in;
            step_s2_q   <= step_s1_q;
            step_prev_q <= step_s2_q;
        end
    end

    possel_pos_t code_w;          // Decoded code word
    logic        step_rise;       // Step edge
    logic        code_chg;        // Code activity
    logic        sack_rise;       // Step confirm edge
    logic        cack_rise;       // Code confirm edge
    assign code_w    = sync2_q[2:0];                        // [R8]
    assign code_chg  = sync2_q[2:0] != prev_q[2:0];         // [R4]
    assign sack_rise = sync2_q[3] & ~prev_q[3];
    assign cack_rise = sync2_q[4] & ~prev_q[4];
    assign step_rise = step_s2_q & ~step_prev_q;

    // ---------------------------------------------------------------
    // Millisecond tick
    // ---------------------------------------------------------------
    logic [15:0] tick_cnt_q;      // Prescaler
    logic        tick_q;          // One-cycle tick
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            tick_cnt_q <= 16'h0000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == 16'(TICK_CYCLES - 1)) begin
            tick_cnt_q <= 16'h0000;
            tick_q     <= 1'b1;   // [R22]
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
            tick_q     <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Wishbone slave: single-cycle ack, ack drops after one cycle
    // ---------------------------------------------------------------
    logic wb_req;                 // New request this cycle
    assign wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
    possel_pos_t pend_q;          // Pre-selected position
    possel_pos_t active_q;        // Active position
    possel_seq_e seq_q;           // Sequence owner
    logic [3:0]  ev_last_q;       // Last logged event
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            wb_ack_out   <= 1'b0;
            wb_dat_out   <= 32'h0000_0000;
            ctrl_q       <= 7'(`PS_CTRL_RESET);
            timeout_ms_q <= `PS_TIMEOUT_RESET;
        end else begin
            wb_ack_out <= wb_req;
            if (wb_req && wb_we_in && wb_sel_in[0]) begin
                unique case (wb_adr_in)
                    `PS_REG_CTRL:    ctrl_q <= wb_dat_in[6:0];
                    `PS_REG_TIMEOUT: timeout_ms_q[7:0] <= wb_dat_in[7:0];
                    default: ;
                endcase
            end
            if (wb_req && wb_we_in && wb_sel_in[1] && wb_adr_in == `PS_REG_TIMEOUT) begin
                timeout_ms_q[15:8] <= wb_dat_in[15:8];
            end
            // Unmapped addresses read zero and still ack
            unique case (wb_adr_in)
                `PS_REG_CTRL:    wb_dat_out <= {25'h0, ctrl_q};
                `PS_REG_TIMEOUT: wb_dat_out <= {16'h0, timeout_ms_q};
                `PS_REG_STATUS:  wb_dat_out <= {19'h0, powerup_alarm, code_range_alarm,
                                                code_confirm_alarm, step_confirm_alarm,
                                                seq_q, 1'b0, pend_q, active_q};
                `PS_REG_EVENT:   wb_dat_out <= {28'h0, ev_last_q};
                default:         wb_dat_out <= 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Time-out timer, restarted by any activity of the owning path
    // ---------------------------------------------------------------
    logic        step_act;        // Accepted step edge
    logic        code_act;        // Accepted code activity
    logic [15:0] to_cnt_q;        // Elapsed ms
    logic        expired;         // Time-out reached
    assign step_act = step_rise && seq_q != POSSEL_CODE;              // [R14]
    assign code_act = code_chg && seq_q != POSSEL_STEP;               // [R14]
    assign expired  = seq_q != POSSEL_IDLE && tick_q && to_cnt_q + 16'h0001 >= timeout_ms_q;
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            to_cnt_q <= 16'h0000;
        end else if (step_act || code_act) begin
            to_cnt_q <= 16'h0000;                                     // [R4]
        end else if (tick_q && seq_q != POSSEL_IDLE) begin
            to_cnt_q <= to_cnt_q + 16'h0001;
        end
    end

    // ---------------------------------------------------------------
    // Power-up: settle on the fourth clock after reset release
    // ---------------------------------------------------------------
    logic boot_q;                 // Power-up pending
    logic [1:0] boot_wait_q;      // Lets synchronisers fill
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            boot_q      <= 1'b1;
            boot_wait_q <= 2'h0;
        end else if (boot_q) begin
            boot_wait_q <= boot_wait_q + 2'h1;
            if (boot_wait_q == 2'h3) begin
                boot_q <= 1'b0;
            end
        end
    end
    logic        boot_fire;       // Power-up decision cycle
    possel_pos_t boot_src;        // Candidate power-up position
    assign boot_fire = boot_q && boot_wait_q == 2'h3;
    assign boot_src  = policy_sync ? code_w : nv_pos_in;              // [R17] [R18]

    // ---------------------------------------------------------------
    // Sequence and position state
    // ---------------------------------------------------------------
    logic apply_step;             // Step pre-selection applied
    logic apply_code;             // Code pre-selection applied
    logic step_fail;              // Step confirm timed out
    logic code_fail;              // Code confirm timed out
    logic range_bad;              // Code above top
    assign apply_step = seq_q == POSSEL_STEP &&
                        (step_ack_mode ? sack_rise : expired);        // [R5] [R6] [R15]
    assign apply_code = seq_q == POSSEL_CODE && !code_act &&
                        (code_ack_mode ? cack_rise : expired);        // [R11] [R12] [R15]
    assign step_fail  = seq_q == POSSEL_STEP && step_ack_mode && !sack_rise && expired;
    assign code_fail  = seq_q == POSSEL_CODE && code_ack_mode && !cack_rise && expired;
    assign range_bad  = !boot_q && code_act && code_w != 3'h0 && code_w > top_w; // [R10]

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            seq_q    <= POSSEL_IDLE;
            pend_q   <= 3'h0;
            active_q <= 3'h0;
        end else if (boot_q) begin
            if (boot_fire) begin
                active_q <= in_range(boot_src, top_w) ? boot_src : 3'h0; // [R17] [R19]
                pend_q   <= in_range(boot_src, top_w) ? boot_src : 3'h0;
            end
        end else if (step_act && !apply_step) begin
            seq_q  <= POSSEL_STEP;
            // Start stepping from the applied position when idle
            pend_q <= ((seq_q == POSSEL_IDLE ? active_q : pend_q) >= top_w) ?
                      3'h1 : (seq_q == POSSEL_IDLE ? active_q : pend_q) + 3'h1; // [R2]
        end else if (code_act) begin
            if (in_range(code_w, top_w)) begin
                seq_q  <= POSSEL_CODE;                                // [R8]
                pend_q <= code_w;
            end else begin
                seq_q  <= POSSEL_IDLE;                                // [R9] [R10]
                pend_q <= active_q;
            end
        end else if (apply_step || apply_code) begin
            active_q <= pend_q;
            seq_q    <= POSSEL_IDLE;
        end else if (step_fail || code_fail) begin
            pend_q <= active_q;                                       // [R7] [R13]
            seq_q  <= POSSEL_IDLE;
        end
    end

    // ---------------------------------------------------------------
    // Outputs: storage, position, events (all registered)
    // ---------------------------------------------------------------
    possel_pos_t active_prev_q;   // Detects position change
    logic        pw_alarm_set;    // Power-up fault found
    assign pw_alarm_set = boot_fire && !in_range(boot_src, top_w);   // [R17] [R19]
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            active_prev_q   <= 3'h0;
            nv_pos_out      <= 3'h0;
            nv_write_out    <= 1'b0;
            pos_onehot_out  <= 7'h00;
            pos_bin_out     <= 3'h0;
            powerup_alarm   <= 1'b0;
            event_valid_out <= 1'b0;
            event_code_out  <= 4'h0;
            ev_last_q       <= 4'h0;
        end else begin
            active_prev_q  <= active_q;
            pos_bin_out    <= active_q;                               // [R21]
            for (int i = 1; i < 8; i++) begin
                pos_onehot_out[i] <= (active_q == 3'(i));             // [R21]
            end
            // Storage is written only on real changes, sparing wear
            nv_write_out <= !boot_q && active_q != active_prev_q;     // [R16]
            nv_pos_out   <= active_q;
            if (pw_alarm_set) begin
                powerup_alarm <= 1'b1;
            end else if (!boot_q && (step_act || code_act)) begin
                powerup_alarm <= 1'b0;   // Cleared by new control activity
            end
            // Position change takes precedence; alarms share the port
            event_valid_out <= 1'b0;
            if (evlog_en && !boot_q && active_q != active_prev_q) begin
                event_valid_out <= 1'b1;                              // [R20]
                event_code_out  <= {1'b0, active_q};
                ev_last_q       <= {1'b0, active_q};
            end else if (evlog_en && (step_fail || code_fail)) begin
                event_valid_out <= 1'b1;                              // [R20]
                event_code_out  <= step_fail ? 4'h8 : 4'h9;
                ev_last_q       <= step_fail ? 4'h8 : 4'h9;
            end
        end
    end

    // ---------------------------------------------------------------
    // Alarm stretchers
    // ---------------------------------------------------------------
    possel_alarm #(.HOLD_MS(ALARM_MS)) u_step_alarm (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .tick_in(tick_q),
        .fire_in(step_fail), .alarm_out(step_confirm_alarm));     // [R7]
    possel_alarm #(.HOLD_MS(ALARM_MS)) u_code_alarm (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .tick_in(tick_q),
        .fire_in(code_fail), .alarm_out(code_confirm_alarm));     // [R13]
    possel_alarm #(.HOLD_MS(ALARM_MS)) u_range_alarm (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .tick_in(tick_q),
        .fire_in(range_bad), .alarm_out(code_range_alarm));       // [R10]

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_pos_in_range: assert property (active_q <= top_w || active_q == 3'h0 || // [R1]
        $changed(top_w) || $past(ctrl_q) != ctrl_q) else $error("position out of range");
    a_step_wrap: assert property (step_act && !apply_step && !boot_q && // [R2]
        (seq_q == POSSEL_STEP ? pend_q : active_q) == top_w |=> pend_q == 3'h1)
        else $error("step did not wrap");
    a_timer_restart: assert property (step_act |=> to_cnt_q == 16'h0000) // [R4]
        else $error("timer not restarted");
    a_step_apply: assert property (apply_step && !boot_q |=> active_q == $past(pend_q)) // [R5]
        else $error("step not applied");
    a_step_ack_only: assert property (seq_q == POSSEL_STEP && step_ack_mode && !sack_rise // [R6]
        && !expired && !step_act |=> $stable(active_q)) else $error("apply without ack");
    a_step_alarm: assert property (step_fail && !boot_q |=> ##1 step_confirm_alarm) // [R7]
        else $error("step alarm missing");
    a_rest_noop: assert property (code_act && code_w == 3'h0 && !boot_q // [R9]
        |=> $stable(active_q)) else $error("rest code acted");
    a_range_alarm: assert property (range_bad |=> ##1 code_range_alarm) // [R10]
        else $error("range alarm missing");
    a_code_apply: assert property (apply_code && !boot_q |=> active_q == $past(pend_q)) // [R11]
        else $error("code not applied");
    a_lockout: assert property (seq_q == POSSEL_STEP && code_chg && !step_rise // [R14]
        |=> seq_q != POSSEL_CODE) else $error("code broke lockout");
    a_onehot_out: assert property (pos_bin_out == 3'h0 |-> pos_onehot_out == 7'h00) // [R21]
        else $error("onehot not clear");
    a_store_write: assert property (!boot_q && $changed(active_q) |=> nv_write_out) // [R16]
        else $error("store missed");

    c_step_apply: cover property (apply_step);
    c_code_apply: cover property (apply_code);
    c_step_fail:  cover property (step_fail);
    c_range_bad:  cover property (range_bad);
endmodule

// ===== tb/possel_nv_model.sv
// Non-volatile store model that holds the selector position across resets
module possel_nv_model (
    input  wire logic       core_clk_in, // System clock
    input  wire logic       write_in,    // Store strobe
    input  wire logic [2:0] pos_in,      // Position to store
    output logic      [2:0] pos_out      // Stored position
);
    timeunit 1ns;
    timeprecision 1ns;
    // Empty store reads 0, which is out of range on purpose
    initial pos_out = 3'h0;
    // Not cleared by the design reset: that is the point of the store
    always @(posedge core_clk_in) begin
        if (write_in === 1'b1) begin
            pos_out <= pos_in;
        end
    end
endmodule

// ===== tb/possel_top_tb.sv
// Self-checking bench for the position selector
`include "possel_regs.svh"
module possel_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        core_clk_in = 1'b0, rst_n_in = 1'b0, wb_cyc_in = 1'b0, wb_we_in = 1'b0;
    logic [2:0]  pin_q = 3'h0, code_q = 3'h0; // Confirm and step pins; code word
    logic [3:0]  wb_adr_in = 4'h0, event_code_out, last_ev = 4'h0;
    logic [31:0] wb_dat_in = 32'h0, wb_dat_out, rdat;
    logic        wb_ack_out, nv_write_out, step_confirm_alarm, code_confirm_alarm;
    logic        code_range_alarm, powerup_alarm, event_valid_out;
    logic [2:0]  nv_pos_in, nv_pos_out, pos_bin_out;
    logic [7:1]  pos_onehot_out;
    int          num_errors = 0, checks_done = 0, ticks = 0;
    typedef struct packed { logic [2:0] code; logic [2:0] pos; } possel_row_s;
    // Code word, then expected position; rest code keeps the last one
    possel_row_s rows [4] = '{'{3'h3, 3'h3}, '{3'h7, 3'h7}, '{3'h0, 3'h7}, '{3'h1, 3'h1}};
    // Short counts keep the run small: 4 clocks a tick, 5 ticks an alarm
    possel_top #(.TICK_CYCLES(4), .ALARM_MS(5)) i_dut (.core_clk_in, .rst_n_in,
        .wb_cyc_in, .wb_stb_in(wb_cyc_in), .wb_we_in, .wb_adr_in, .wb_sel_in(4'h3),
        .wb_dat_in, .wb_dat_out, .wb_ack_out, .step_pulse_in(pin_q[0]),
        .step_confirm_in(pin_q[1]), .code_confirm_in(pin_q[2]), .code_bit_0(code_q[0]),
        .code_bit_1(code_q[1]), .code_bit_2(code_q[2]), .nv_pos_in, .nv_pos_out,
        .nv_write_out, .pos_onehot_out, .pos_bin_out, .step_confirm_alarm,
        .code_confirm_alarm, .code_range_alarm, .powerup_alarm, .event_valid_out,
        .event_code_out);
    possel_nv_model i_nv (.core_clk_in, .write_in(nv_write_out), .pos_in(nv_pos_out),
        .pos_out(nv_pos_in));
    always #12.5 core_clk_in = ~core_clk_in;
    // Event catcher and hang guard
    always @(posedge core_clk_in) begin
        ticks++;
        if (event_valid_out === 1'b1) last_ev <= event_code_out;
        if (ticks == 20000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic cy(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    // Classic single cycle; waits for ack, never assumes its latency
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        wb_cyc_in <= 1'b1;
        wb_we_in <= w;
        wb_adr_in <= a;
        wb_dat_in <= d;
        do @(posedge core_clk_in); while (wb_ack_out !== 1'b1);
        rdat = wb_dat_out;
        wb_cyc_in <= 1'b0;
    endtask
    // Held long enough to pass the input synchronisers
    task automatic pulse(input int b);
        @(posedge core_clk_in);
        pin_q[b] <= 1'b1;
        cy(6);
        @(posedge core_clk_in);
        pin_q[b] <= 1'b0;
    endtask
    task automatic setc(input logic [2:0] v);
        @(posedge core_clk_in);
        code_q <= v;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pos(input logic [2:0] p);
        cmp({29'h0, pos_bin_out}, {29'h0, p});
        cmp({25'h0, pos_onehot_out}, (p == 3'h0) ? 32'h0 : 32'h1 << (p - 3'h1));
    endtask
    // Reset, an optional setup write ahead of the power-up decision, then its result
    task automatic reboot(input logic [31:0] c, input logic [2:0] p, input logic a);
        @(posedge core_clk_in);
        rst_n_in <= 1'b0;
        cy(10);
        @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        if (c != 32'h0) wb(1'b1, `PS_REG_CTRL, c); // Lands before the power-up decision
        cy(8);
        chk_pos(p);
        cmp(powerup_alarm, a);
    endtask
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        reboot(32'h0, 3'h0, 1'b1);
        wb(1'b0, `PS_REG_CTRL, 0);
        cmp(rdat, `PS_CTRL_RESET);
        wb(1'b0, 4'h2, 0);
        cmp(rdat, 0);
        wb(1'b1, `PS_REG_TIMEOUT, 32'd60); // 60 ms, longer than the 50 ms step spacing
        foreach (rows[i]) begin
            setc(rows[i].code);
            cy(300);
            chk_pos(rows[i].pos);
        end
        $display("code rows done");
        wb(1'b1, `PS_REG_CTRL, 32'h3);
        pulse(0);
        cy(200);
        setc(3'h2); // Locked out while the step sequence runs
        pulse(0);
        cy(100);
        chk_pos(3'h1);
        cy(200);
        chk_pos(3'h3);
        pulse(0);
        cy(300);
        chk_pos(3'h1);
        setc(3'h5);
        cy(10);
        cmp(code_range_alarm, 1);
        chk_pos(3'h1);
        cy(30);
        cmp(code_range_alarm, 0);
        setc(3'h0);
        $display("step and range done");
        wb(1'b1, `PS_REG_CTRL, 32'h4b);
        pulse(0);
        pulse(2);
        cy(10);
        chk_pos(3'h1);
        pulse(1);
        cy(10);
        chk_pos(3'h2);
        cmp(last_ev, 2);
        cy(200);
        pulse(0);
        cy(250);
        cmp(step_confirm_alarm, 1);
        chk_pos(3'h2);
        cmp(last_ev, 8);
        $display("step confirm done");
        wb(1'b1, `PS_REG_CTRL, 32'h53);
        setc(3'h3);
        cy(20);
        pulse(1);
        pulse(2);
        cy(10);
        chk_pos(3'h3);
        setc(3'h1);
        cy(260);
        cmp(code_confirm_alarm, 1);
        chk_pos(3'h3);
        cmp(last_ev, 9);
        $display("code confirm done");
        reboot(32'h0, 3'h3, 1'b0);
        reboot(32'h22, 3'h1, 1'b0);
        setc(3'h5);
        reboot(32'h23, 3'h0, 1'b1);
        setc(3'h0);
        reboot(32'h27, 3'h0, 1'b1);
        $display("power-up done");
        print_verdict();
    end
endmodule
